// file: design/dfsb_top.sv
// Diagnostic fault status bank with a classic Wishbone register port
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
module dfsb_top
  import dfsb_pkg::*;
(
  input  wire logic                               clk_in,
  input  wire logic                               sys_rst_in,
  input  wire dfsb_pkg::dfsb_wb_req_s             wb_req_in,
  output logic      [dfsb_pkg::WB_DW-1:0]         wb_dat_out,
  output logic                                    wb_ack_out,
  input  wire dfsb_pkg::dfsb_temp_cmp_s           temp_cmp_in,
  input  wire logic                               input_meas_valid_in,
  input  wire logic [7:0][15:0]                   main_input_reading_in,
  input  wire logic [7:0][15:0]                   aux_input_reading_in,
  input  wire logic                               cell_meas_valid_in,
  input  wire logic [15:0][15:0]                  main_cell_reading_in,
  input  wire logic [15:0][15:0]                  auxiliary_cell_reading_in,
  input  wire logic                               open_wire_run_in,
  input  wire logic                               balance_run_in,
  input  wire logic [15:0]                        balancing_switch_open_in,
  output logic                                    irq_out
);

  // Word hit on a register index; byte lanes below the word must be zero
  function automatic logic reg_hit(input logic [WB_AW-1:0] adr,
                                   input logic [13:0]      idx);
    reg_hit = (adr[WB_AW-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // Status registers
  logic [7:0]       overtemp_input_flags_q;
  logic [7:0]       undertemp_input_flags_q;
  logic [7:0]       input_crosscheck_fail_q;
  logic [7:0]       cell_crosscheck_fail_hi_q;
  logic [7:0]       cell_crosscheck_fail_lo_q;
  logic [7:0]       sense_open_wire_fail_hi_q;
  logic [7:0]       sense_open_wire_fail_lo_q;
  logic [7:0]       balance_open_wire_fail_hi_q;
  logic [7:0]       balance_open_wire_fail_lo_q;

  // Next values of the status registers
  logic [7:0]       overtemp_input_flags_d;
  logic [7:0]       undertemp_input_flags_d;
  logic [7:0]       input_crosscheck_fail_d;
  logic [7:0]       cell_crosscheck_fail_hi_d;
  logic [7:0]       cell_crosscheck_fail_lo_d;
  logic [7:0]       sense_open_wire_fail_hi_d;
  logic [7:0]       sense_open_wire_fail_lo_d;
  logic [7:0]       balance_open_wire_fail_hi_d;
  logic [7:0]       balance_open_wire_fail_lo_d;

  // Configuration registers
  logic [2:0]       input_crosscheck_limit_q;
  logic [4:0]       cell_crosscheck_limit_q;
  logic [3:0]       open_wire_limit_q;
  logic [N_EVT-1:0] evt_en_q;

  // Bus answer registers
  logic             ack_q;
  logic [WB_DW-1:0] rdat_q;
  logic [WB_DW-1:0] rdat_d;

  // Bus strobes
  logic             bus_req;
  logic             wr_take;
  logic             rd_take;

  // Check results and events
  logic [N_IN-1:0]  in_fail;
  logic [N_CEL-1:0] cell_fail;
  logic [N_CEL-1:0] sense_open;
  logic [RD_W-1:0]  in_limit;
  logic [RD_W-1:0]  cell_limit;
  logic [RD_W-1:0]  ow_limit;
  logic [N_EVT-1:0] evt;
  logic [N_EVT-1:0] evt_clr;
  logic [N_EVT-1:0] evt_stat;
  logic             irq;

  // A request is answered once; ack drops the cycle after it was given
  assign bus_req = wb_req_in.cyc && wb_req_in.stb && !ack_q;
  assign wr_take = bus_req && wb_req_in.we;
  assign rd_take = bus_req && !wb_req_in.we;

  // Limit codes scaled into reading LSBs
  assign in_limit   = RD_W'({input_crosscheck_limit_q, IN_LIM_SHIFT'(0)});
  assign cell_limit = RD_W'({cell_crosscheck_limit_q, CELL_LIM_SHIFT'(0)});
  assign ow_limit   = RD_W'({open_wire_limit_q, OW_LIM_SHIFT'(0)});

  // Input main against auxiliary comparison
  // input limit compare
  dfsb_diff_check #(
    .N        (N_IN),
    .W        (RD_W)
  ) u_input_check (
    .main_in  (main_input_reading_in),
    .aux_in   (aux_input_reading_in),
    .limit_in (in_limit),
    .fail_out (in_fail)
  );

  // Cell main against auxiliary comparison
  // cell limit compare
  dfsb_diff_check #(
    .N        (N_CEL),
    .W        (RD_W)
  ) u_cell_check (
    .main_in  (main_cell_reading_in),
    .aux_in   (auxiliary_cell_reading_in),
    .limit_in (cell_limit),
    .fail_out (cell_fail)
  );

  // Open sense wire shows as a cell reading below the limit
  for (genvar c = 0; c < N_CEL; c++) begin : g_sense
    assign sense_open[c] = main_cell_reading_in[c] < ow_limit;
  end

  // Temperature comparator results, taken on their strobe; the flags
  // follow the latest comparator run rather than latching forever
  always_comb begin
    overtemp_input_flags_d  = overtemp_input_flags_q;
    undertemp_input_flags_d = undertemp_input_flags_q;
    if (temp_cmp_in.valid) begin
      overtemp_input_flags_d  = temp_cmp_in.over;
      undertemp_input_flags_d = temp_cmp_in.under;
    end
  end

  // Temperature flag registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      overtemp_input_flags_q  <= STAT_RST;
      undertemp_input_flags_q <= STAT_RST;
    end else begin
      overtemp_input_flags_q  <= overtemp_input_flags_d;
      undertemp_input_flags_q <= undertemp_input_flags_d;
    end
  end

  // Input cross-check results; a pass clears the bit again
  always_comb begin
    input_crosscheck_fail_d = input_crosscheck_fail_q;
    if (input_meas_valid_in) begin
      input_crosscheck_fail_d = in_fail;
    end
  end

  // Input cross-check register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_crosscheck_fail_q <= STAT_RST;
    end else begin
      input_crosscheck_fail_q <= input_crosscheck_fail_d;
    end
  end

  // Cell cross-check results split into two byte registers
  always_comb begin
    cell_crosscheck_fail_hi_d = cell_crosscheck_fail_hi_q;
    cell_crosscheck_fail_lo_d = cell_crosscheck_fail_lo_q;
    if (cell_meas_valid_in) begin
      cell_crosscheck_fail_hi_d = cell_fail[15:8];
      cell_crosscheck_fail_lo_d = cell_fail[7:0];
    end
  end

  // Cell cross-check registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cell_crosscheck_fail_hi_q <= STAT_RST;
      cell_crosscheck_fail_lo_q <= STAT_RST;
    end else begin
      cell_crosscheck_fail_hi_q <= cell_crosscheck_fail_hi_d;
      cell_crosscheck_fail_lo_q <= cell_crosscheck_fail_lo_d;
    end
  end

  // Sense open-wire results, taken in every cycle open_wire_run_in is high; the
  // readings must already be settled in that cycle
  always_comb begin
    sense_open_wire_fail_hi_d = sense_open_wire_fail_hi_q;
    sense_open_wire_fail_lo_d = sense_open_wire_fail_lo_q;
    if (open_wire_run_in) begin
      sense_open_wire_fail_hi_d = sense_open[15:8];
      sense_open_wire_fail_lo_d = sense_open[7:0];
    end
  end

  // Sense open-wire registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sense_open_wire_fail_hi_q <= STAT_RST;
      sense_open_wire_fail_lo_q <= STAT_RST;
    end else begin
      sense_open_wire_fail_hi_q <= sense_open_wire_fail_hi_d;
      sense_open_wire_fail_lo_q <= sense_open_wire_fail_lo_d;
    end
  end

  // Balancing switch open-wire results from the switch diagnostic
  always_comb begin
    balance_open_wire_fail_hi_d = balance_open_wire_fail_hi_q;
    balance_open_wire_fail_lo_d = balance_open_wire_fail_lo_q;
    if (balance_run_in) begin
      balance_open_wire_fail_hi_d = balancing_switch_open_in[15:8];
      balance_open_wire_fail_lo_d = balancing_switch_open_in[7:0];
    end
  end

  // Balancing switch open-wire registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      balance_open_wire_fail_hi_q <= STAT_RST;
      balance_open_wire_fail_lo_q <= STAT_RST;
    end else begin
      balance_open_wire_fail_hi_q <= balance_open_wire_fail_hi_d;
      balance_open_wire_fail_lo_q <= balance_open_wire_fail_lo_d;
    end
  end

  // Events: a result strobe that carries at least one failing channel
  assign evt[EVT_TEMP] = temp_cmp_in.valid &&
                         |(temp_cmp_in.over | temp_cmp_in.under);
  assign evt[EVT_INXC] = input_meas_valid_in && |in_fail;
  assign evt[EVT_CLXC] = cell_meas_valid_in && |cell_fail;
  assign evt[EVT_SOW]  = open_wire_run_in && |sense_open;
  assign evt[EVT_BOW]  = balance_run_in && |balancing_switch_open_in;

  // Clear strobes come from a write to the clear register
  assign evt_clr = (wr_take && wb_req_in.sel[0] &&
                    reg_hit(wb_req_in.adr, IDX_EVT_CLR))
                   ? wb_req_in.dat[N_EVT-1:0] : '0;

  // Sticky event flags and the interrupt level
  dfsb_event_irq u_evt (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .event_in   (evt),
    .clear_in   (evt_clr),
    .enable_in  (evt_en_q),
    .status_out (evt_stat),
    .irq_out    (irq)
  );

  // Limits register; each field sits in its own byte lane
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_crosscheck_limit_q <= IN_LIM_RST;
      cell_crosscheck_limit_q  <= CELL_LIM_RST;
      open_wire_limit_q        <= OW_LIM_RST;
    end else if (wr_take && reg_hit(wb_req_in.adr, IDX_LIMITS)) begin
      if (wb_req_in.sel[0]) begin
        input_crosscheck_limit_q <= wb_req_in.dat[IN_LIM_LSB +: 3];
      end
      if (wb_req_in.sel[1]) begin
        cell_crosscheck_limit_q <= wb_req_in.dat[CELL_LIM_LSB +: 5];
      end
      if (wb_req_in.sel[2]) begin
        open_wire_limit_q <= wb_req_in.dat[OW_LIM_LSB +: 4];
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_en_q <= EVT_EN_RST;
    end else if (wr_take && wb_req_in.sel[0] &&
                 reg_hit(wb_req_in.adr, IDX_EVT_EN)) begin
      evt_en_q <= wb_req_in.dat[N_EVT-1:0];
    end
  end

  // Read multiplexer; unmapped and write-only words read as zero.
  // Status words have no write path at all, so writes there only ack.
  // read-only status
  always_comb begin
    rdat_d = '0;
    if (reg_hit(wb_req_in.adr, IDX_OVERTEMP)) begin
      rdat_d[7:0] = overtemp_input_flags_q;
    end else if (reg_hit(wb_req_in.adr, IDX_UNDERTEMP)) begin
      rdat_d[7:0] = undertemp_input_flags_q;
    end else if (reg_hit(wb_req_in.adr, IDX_IN_XCHK)) begin
      rdat_d[7:0] = input_crosscheck_fail_q;
    end else if (reg_hit(wb_req_in.adr, IDX_CELL_XC_HI)) begin
      rdat_d[7:0] = cell_crosscheck_fail_hi_q;
    end else if (reg_hit(wb_req_in.adr, IDX_CELL_XC_LO)) begin
      rdat_d[7:0] = cell_crosscheck_fail_lo_q;
    end else if (reg_hit(wb_req_in.adr, IDX_SOW_HI)) begin
      rdat_d[7:0] = sense_open_wire_fail_hi_q;
    end else if (reg_hit(wb_req_in.adr, IDX_SOW_LO)) begin
      rdat_d[7:0] = sense_open_wire_fail_lo_q;
    end else if (reg_hit(wb_req_in.adr, IDX_BOW_HI)) begin
      rdat_d[7:0] = balance_open_wire_fail_hi_q;
    end else if (reg_hit(wb_req_in.adr, IDX_BOW_LO)) begin
      rdat_d[7:0] = balance_open_wire_fail_lo_q;
    end else if (reg_hit(wb_req_in.adr, IDX_LIMITS)) begin
      rdat_d[IN_LIM_LSB +: 3]   = input_crosscheck_limit_q;
      rdat_d[CELL_LIM_LSB +: 5] = cell_crosscheck_limit_q;
      rdat_d[OW_LIM_LSB +: 4]   = open_wire_limit_q;
    end else if (reg_hit(wb_req_in.adr, IDX_EVT_STAT)) begin
      rdat_d[N_EVT-1:0] = evt_stat;
    end else if (reg_hit(wb_req_in.adr, IDX_EVT_EN)) begin
      rdat_d[N_EVT-1:0] = evt_en_q;
    end
  end

  // Single-cycle answer; every address acks so a master never hangs
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read data is captured with the ack and held until the next read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdat_q <= '0;
    end else if (rd_take) begin
      rdat_q <= rdat_d;
    end
  end

  // Outputs come straight from their flip-flops
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  assign irq_out    = irq;

endmodule

// file: design/dfsb_pkg.sv
// Constants and carrier types for the diagnostic fault status bank
package dfsb_pkg;
  // Bus and data widths
  localparam int unsigned WB_AW = 16;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned RD_W  = 16;
  localparam int unsigned N_IN  = 8;
  localparam int unsigned N_CEL = 16;
  localparam int unsigned N_EVT = 5;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_OVERTEMP   = 14'h0540;
  localparam logic [13:0] IDX_UNDERTEMP  = 14'h0541;
  localparam logic [13:0] IDX_IN_XCHK    = 14'h0543;
  localparam logic [13:0] IDX_CELL_XC_HI = 14'h0545;
  localparam logic [13:0] IDX_CELL_XC_LO = 14'h0546;
  localparam logic [13:0] IDX_SOW_HI     = 14'h0548;
  localparam logic [13:0] IDX_SOW_LO     = 14'h0549;
  localparam logic [13:0] IDX_BOW_HI     = 14'h054B;
  localparam logic [13:0] IDX_BOW_LO     = 14'h054C;
  localparam logic [13:0] IDX_LIMITS     = 14'h0560;
  localparam logic [13:0] IDX_EVT_STAT   = 14'h0561;
  localparam logic [13:0] IDX_EVT_CLR    = 14'h0562;
  localparam logic [13:0] IDX_EVT_EN     = 14'h0563;

  // Status reset value
  localparam logic [7:0] STAT_RST = 8'h00;

  // Limits register layout and reset values
  localparam int unsigned IN_LIM_LSB   = 0;
  localparam int unsigned CELL_LIM_LSB = 8;
  localparam int unsigned OW_LIM_LSB   = 16;
  localparam logic [2:0]  IN_LIM_RST   = 3'h7;
  localparam logic [4:0]  CELL_LIM_RST = 5'h1F;
  localparam logic [3:0]  OW_LIM_RST   = 4'h0;
  localparam logic [4:0]  EVT_EN_RST   = 5'h00;

  // Scale of each limit code in reading LSBs (left shift)
  localparam int unsigned IN_LIM_SHIFT   = 4;
  localparam int unsigned CELL_LIM_SHIFT = 3;
  localparam int unsigned OW_LIM_SHIFT   = 10;

  // Event bit positions
  localparam int unsigned EVT_TEMP = 0;
  localparam int unsigned EVT_INXC = 1;
  localparam int unsigned EVT_CLXC = 2;
  localparam int unsigned EVT_SOW  = 3;
  localparam int unsigned EVT_BOW  = 4;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic               cyc;
    logic               stb;
    logic               we;
    logic [3:0]         sel;
    logic [WB_AW-1:0]   adr;
    logic [WB_DW-1:0]   dat;
  } dfsb_wb_req_s;

  // Temperature comparator results with their strobe
  typedef struct packed {
    logic               valid;
    logic [N_IN-1:0]    over;
    logic [N_IN-1:0]    under;
  } dfsb_temp_cmp_s;
endpackage

// file: design/dfsb_diff_check.sv
// Per-channel check that two readings differ by more than a limit
`timescale 1ns/10ps
module dfsb_diff_check #(
  parameter int unsigned N = 8,
  parameter int unsigned W = 16
) (
  input  wire logic [N-1:0][W-1:0] main_in,
  input  wire logic [N-1:0][W-1:0] aux_in,
  input  wire logic [W-1:0]        limit_in,
  output logic      [N-1:0]        fail_out
);
  // One magnitude comparator per channel
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [W-1:0] diff;
    // Subtract the smaller from the larger so no sign bit is needed
    assign diff = (main_in[i] >= aux_in[i]) ? main_in[i] - aux_in[i]
                                            : aux_in[i] - main_in[i];
    // Equal to the limit still passes
    assign fail_out[i] = diff > limit_in;
  end
endmodule

// file: design/dfsb_event_irq.sv
// Sticky event flags, enable gating and the level interrupt
`timescale 1ns/10ps
module dfsb_event_irq
  import dfsb_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [N_EVT-1:0] event_in,
  input  wire logic [N_EVT-1:0] clear_in,
  input  wire logic [N_EVT-1:0] enable_in,
  output logic      [N_EVT-1:0] status_out,
  output logic                  irq_out
);
  logic [N_EVT-1:0] stat_q;
  logic [N_EVT-1:0] stat_d;

  // A new event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~clear_in) | event_in;

  // Sticky flags
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Interrupt changes with the flags, from a flop fed by the next flag value
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_d & enable_in);
    end
  end

  assign status_out = stat_q;
endmodule

// file: bench/dfsb_top_sva.sv
// Port-level assertions for the diagnostic fault status bank
`timescale 1ns/10ps
module dfsb_top_sva
  import dfsb_pkg::*;
(
  input wire logic                        clk_in,
  input wire logic                        sys_rst_in,
  input wire dfsb_pkg::dfsb_wb_req_s      wb_req_in,
  input wire logic [dfsb_pkg::WB_DW-1:0]  wb_dat_out,
  input wire logic                        wb_ack_out,
  input wire dfsb_pkg::dfsb_temp_cmp_s    temp_cmp_in,
  input wire logic                        input_meas_valid_in,
  input wire logic                        cell_meas_valid_in,
  input wire logic                        open_wire_run_in,
  input wire logic                        balance_run_in,
  input wire logic [15:0]                 balancing_switch_open_in,
  input wire logic                        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic        taken;
  logic        rd_tk;
  logic        cause_q;
  logic        wr_q;
  logic [7:0]  ot_q;
  logic [7:0]  ut_q;
  logic [15:0] bow_q;
  // A request is taken only while no answer is standing
  assign taken = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  assign rd_tk = taken && !wb_req_in.we;
  // Shadow of the results that arrive already computed
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ot_q  <= 8'h00;
      ut_q  <= 8'h00;
      bow_q <= 16'h0000;
    end else begin
      if (temp_cmp_in.valid) begin
        ot_q <= temp_cmp_in.over;
        ut_q <= temp_cmp_in.under;
      end
      if (balance_run_in) begin
        bow_q <= balancing_switch_open_in;
      end
    end
  end
  // Anything that may raise the interrupt, one cycle late; an enable
  // write shows on the interrupt one cycle later still
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_q    <= 1'b0;
      cause_q <= 1'b0;
    end else begin
      wr_q    <= taken && wb_req_in.we;
      cause_q <= temp_cmp_in.valid || input_meas_valid_in ||
                 cell_meas_valid_in || open_wire_run_in ||
                 balance_run_in || (taken && wb_req_in.we) || wr_q;
    end
  end
  ot_read_a: assert property (
    rd_tk && wb_req_in.adr == {IDX_OVERTEMP, 2'h0}
    |=> wb_dat_out == {24'h000000, $past(ot_q)})
    else $error("over-temp read");
  ut_read_a: assert property (
    rd_tk && wb_req_in.adr == {IDX_UNDERTEMP, 2'h0}
    |=> wb_dat_out == {24'h000000, $past(ut_q)})
    else $error("under-temp read");
  bow_hi_a: assert property (
    rd_tk && wb_req_in.adr == {IDX_BOW_HI, 2'h0}
    |=> wb_dat_out == {24'h000000, $past(bow_q[15:8])})
    else $error("bow hi");
  bow_lo_a: assert property (
    rd_tk && wb_req_in.adr == {IDX_BOW_LO, 2'h0}
    |=> wb_dat_out == {24'h000000, $past(bow_q[7:0])})
    else $error("bow lo");
  ack_pulse_a: assert property (taken |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single pulse");
  idle_ack_a: assert property (!(wb_req_in.cyc && wb_req_in.stb)
    |=> !wb_ack_out) else $error("ack without request");
  dat_hold_a: assert property (!rd_tk |=> $stable(wb_dat_out))
    else $error("read data moved");
  rst_quiet_a: assert property ($past(sys_rst_in)
    |-> !wb_ack_out && !irq_out) else $error("busy after reset");
  irq_cause_a: assert property ($rose(irq_out) |-> cause_q)
    else $error("interrupt without cause");
  cover property (rd_tk && wb_req_in.adr == {IDX_OVERTEMP, 2'h0});
  cover property ($rose(irq_out));
  cover property (taken && wb_req_in.we);
endmodule
bind dfsb_top dfsb_top_sva dfsb_top_sva_i (.clk_in, .sys_rst_in, .wb_req_in,
  .wb_dat_out, .wb_ack_out, .temp_cmp_in, .input_meas_valid_in,
  .cell_meas_valid_in, .open_wire_run_in, .balance_run_in,
  .balancing_switch_open_in, .irq_out);

// file: bench/dfsb_top_tb.sv
// Self-checking bench for the diagnostic fault status bank
`timescale 1ns/10ps
module dfsb_top_tb;
  import dfsb_pkg::*;
  logic             clk_in, sys_rst_in, ack, irq;
  logic             in_vld, cell_vld, ow_run, bal_run;
  dfsb_wb_req_s     req;
  dfsb_temp_cmp_s   temp;
  logic [31:0]      rdat, tmp;
  logic [7:0][15:0] in_main, in_aux;
  logic [15:0][15:0] cell_main, cell_aux;
  logic [15:0]      sw_open;
  int               error_cnt, n_compared, cyc_cnt;
  dfsb_top dfsb_top_i (
    .clk_in                    (clk_in),
    .sys_rst_in                (sys_rst_in),
    .wb_req_in                 (req),
    .wb_dat_out                (rdat),
    .wb_ack_out                (ack),
    .temp_cmp_in               (temp),
    .input_meas_valid_in       (in_vld),
    .main_input_reading_in     (in_main),
    .aux_input_reading_in      (in_aux),
    .cell_meas_valid_in        (cell_vld),
    .main_cell_reading_in      (cell_main),
    .auxiliary_cell_reading_in (cell_aux),
    .open_wire_run_in          (ow_run),
    .balance_run_in            (bal_run),
    .balancing_switch_open_in  (sw_open),
    .irq_out                   (irq)
  );
  // Free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; waits on ack, the bench timeout ends a hang
  task automatic wb(input logic w, input logic [13:0] idx,
                    input logic [31:0] wd, output logic [31:0] rd);
    req <= '{1'b1, 1'b1, w, 4'hF, {idx, 2'h0}, wd};
    do @(posedge clk_in); while (ack !== 1'b1);
    rd = rdat;
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 32'h0, tmp);
    chk(tmp, {24'h0, exp});
  endtask
  // One-cycle strobe of a result source: 0 temp, 1 input, 2 cell, 3 ow, 4 bal
  task automatic pulse(input int k);
    case (k)
      0: temp.valid <= 1'b1;
      1: in_vld <= 1'b1;
      2: cell_vld <= 1'b1;
      3: ow_run <= 1'b1;
      default: bal_run <= 1'b1;
    endcase
    @(posedge clk_in);
    {temp.valid, in_vld, cell_vld, ow_run, bal_run} <= 5'h00;
    @(posedge clk_in);
  endtask
  task automatic t_reset;
    logic [13:0] idx [9] = '{IDX_OVERTEMP, IDX_UNDERTEMP, IDX_IN_XCHK,
      IDX_CELL_XC_HI, IDX_CELL_XC_LO, IDX_SOW_HI, IDX_SOW_LO,
      IDX_BOW_HI, IDX_BOW_LO};
    foreach (idx[i]) rd_chk(idx[i], 8'h00);
    rd_chk(14'h0542, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, IDX_LIMITS, 32'h0, tmp);
    chk(tmp, 32'h0000_1F07);
  endtask
  task automatic t_temp;
    wb(1'b1, IDX_EVT_EN, 32'h1, tmp);
    temp.over <= 8'hA5;
    temp.under <= 8'h3C;
    pulse(0);
    chk({31'h0, irq}, 32'h1);
    rd_chk(IDX_OVERTEMP, 8'hA5);
    rd_chk(IDX_UNDERTEMP, 8'h3C);
    wb(1'b1, IDX_OVERTEMP, 32'hFF, tmp);
    rd_chk(IDX_OVERTEMP, 8'hA5);
    wb(1'b1, IDX_EVT_CLR, 32'h1F, tmp);
    chk({31'h0, irq}, 32'h0);
    temp.over <= 8'h00;
    temp.under <= 8'h00;
    pulse(0);
    rd_chk(IDX_UNDERTEMP, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, IDX_EVT_EN, 32'h0, tmp);
  endtask
  // Differences of 32 pass and 33 fail, in both directions
  task automatic t_xchk;
    for (int i = 0; i < 8; i++) begin
      in_main[i] <= 16'd1000;
      in_aux[i] <= i[0] ? 16'd1000 + (8'h96 >> i & 1) + 16'd32
                        : 16'd968 - (8'h96 >> i & 1);
    end
    for (int i = 0; i < 16; i++) begin
      cell_main[i] <= 16'h4000;
      cell_aux[i] <= i[0] ? 16'h4020 + (16'hC3A5 >> i & 1)
                          : 16'h3FE0 - (16'hC3A5 >> i & 1);
    end
    pulse(1);
    pulse(2);
    rd_chk(IDX_IN_XCHK, 8'h96);
    rd_chk(IDX_CELL_XC_HI, 8'hC3);
    rd_chk(IDX_CELL_XC_LO, 8'hA5);
  endtask
  // Readings one below the 2048 limit fail, equal passes
  task automatic t_open;
    for (int i = 0; i < 16; i++) begin
      cell_main[i] <= 16'd2048 - (16'h5A0F >> i & 1);
    end
    pulse(3);
    rd_chk(IDX_SOW_HI, 8'h5A);
    rd_chk(IDX_SOW_LO, 8'h0F);
    sw_open <= 16'h9C31;
    pulse(4);
    rd_chk(IDX_BOW_HI, 8'h9C);
    rd_chk(IDX_BOW_LO, 8'h31);
    sw_open <= 16'h0000;
    pulse(4);
    rd_chk(IDX_BOW_LO, 8'h00);
    rd_chk(IDX_EVT_STAT, 8'h1E);
  endtask
  // Reset, set the three limits, then each scenario in turn
  initial begin
    sys_rst_in = 1'b1;
    req = '0;
    temp = '0;
    {in_vld, cell_vld, ow_run, bal_run} = 4'h0;
    in_main = '0;
    in_aux = '0;
    cell_main = '0;
    cell_aux = '0;
    sw_open = 16'h0000;
    error_cnt = 0;
    n_compared = 0;
    cyc_cnt = 0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    wb(1'b1, IDX_LIMITS, 32'h0002_0402, tmp);
    t_temp();
    t_xchk();
    t_open();
    final_report();
  end
endmodule
